// ===== verilog/pdcb_card.sv
// bus slave front end of the paged dram card
// assumes all backplane strobes are synchronous to clk and the ram
// behind it answers a read one cycle after ram_rd
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module pdcb_card (
    // clock and system reset
    input wire logic clk,
    input wire logic rst_n,
    // backplane address and data
    input wire logic [pdcb_pkg::ADDR_W-1:0] addr,
    input wire logic [pdcb_pkg::DATA_W-1:0] data_in,
    output logic [pdcb_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    // backplane control strobes, active low
    input wire logic mcsync_n,
    input wire logic memreq_n,
    input wire logic iorq_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic refresh_n,
    input wire logic m1_n,
    // processor emulation mode of the master
    input wire logic emul_mode,
    // static jumpers
    input wire logic [pdcb_pkg::PORT_ADDR_W-1:0] port_number_jumpers,
    input wire logic [pdcb_pkg::PAGES-1:0] page_select_jumpers,
    // dram side
    output logic [pdcb_pkg::RAM_ADDR_W-1:0] ram_addr,
    output logic [pdcb_pkg::RAM_WORD_W-1:0] ram_wdata,
    output logic ram_we,
    output logic ram_rd,
    input wire logic [pdcb_pkg::RAM_WORD_W-1:0] ram_rdata,
    output logic refresh_req,
    output logic [pdcb_pkg::REFR_ROW_W-1:0] refresh_row,
    // status
    output logic card_enable,
    output logic parity_error_flag
);
    import pdcb_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        pdcb_cyc_e cyc;
        logic [HI_ADDR_W-1:0] hi_addr;
        logic card_en;
        logic par_err;
        logic rd_d;
        logic wr_d;
        logic mreq_d;
        logic rd_pend;
        logic [DATA_W-1:0] dout;
        logic ram_we;
        logic ram_rd;
        logic [RAM_ADDR_W-1:0] ram_addr;
        logic [RAM_WORD_W-1:0] ram_wdata;
        logic refr_req;
        logic [REFR_ROW_W-1:0] refr_row;
    } pdcb_state_s;

    localparam pdcb_state_s STATE_RESET = '{
        cyc: PDCB_IDLE,
        hi_addr: HI_ADDR_RESET,
        card_en: CARD_EN_RESET,
        par_err: PARERR_RESET,
        rd_d: 1'b1,
        wr_d: 1'b1,
        mreq_d: 1'b1,
        rd_pend: 1'b0,
        dout: DOUT_RESET,
        ram_we: 1'b0,
        ram_rd: 1'b0,
        ram_addr: RAM_ADDR_RESET,
        ram_wdata: RAM_WDATA_RESET,
        refr_req: 1'b0,
        refr_row: REFR_ROW_RESET
    };

    pdcb_state_s st;
    pdcb_state_s next_st;

    // =========================================================
    // decoding helpers

    // page chosen by the top two latched address bits
    function automatic logic page_hit(
        input logic [HI_ADDR_W-1:0] hi,
        input logic [PAGES-1:0] jumpers
    );
        logic [1:0] page;
        page = hi[PAGE_SEL_MSB:PAGE_SEL_LSB];
        // only the fitted jumper of the addressed page matches
        page_hit = jumpers[page];
    endfunction

    // port match over the low eight address bits only
    function automatic logic port_hit(
        input logic [ADDR_W-1:0] a,
        input logic [PORT_ADDR_W-1:0] jumpers
    );
        // open jumper reads one, fitted reads zero, bit by bit
        port_hit = (a[PORT_ADDR_W-1:0] == jumpers);
    endfunction

    // =========================================================
    // parity unit
    logic gen_parity;
    logic chk_error;

    pdcb_parity_unit i_pdcb_parity_unit (
        .wr_byte(data_in),
        .wr_parity(gen_parity),
        .rd_word(ram_rdata),
        .rd_error(chk_error)
    );

    // =========================================================
    // combinational decode of the present bus cycle
    logic mem_strobe;
    logic refr_cycle;
    logic mem_cycle;
    logic mem_sel;
    logic io_valid;
    logic io_sel;
    logic rd_fall;
    logic wr_fall;
    logic mreq_fall;
    logic [FULL_ADDR_W-1:0] full_addr;

    // expansion lines are not inputs at all, so they gate nothing
    always_comb begin
        mem_strobe = ~memreq_n;
        // refresh needs memreq as qualifier
        refr_cycle = mem_strobe & ~refresh_n;
        // memory only while memreq active and not refreshing
        mem_cycle = mem_strobe & refresh_n;
        full_addr = {st.hi_addr, addr};
        mem_sel = mem_cycle & st.card_en
            & page_hit(st.hi_addr, page_select_jumpers);
        // io strobe counts only in emulation mode, never with m1
        io_valid = ~iorq_n & emul_mode & m1_n;
        io_sel = io_valid & port_hit(addr, port_number_jumpers);
        rd_fall = st.rd_d & ~rd_n;
        wr_fall = st.wr_d & ~wr_n;
        mreq_fall = st.mreq_d & mem_strobe;
    end

    // =========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.rd_d = rd_n;
        next_st.wr_d = wr_n;
        next_st.mreq_d = memreq_n;
        next_st.ram_we = 1'b0;
        next_st.ram_rd = 1'b0;
        next_st.refr_req = 1'b0;
        next_st.rd_pend = 1'b0;

        // high address follows d0-d3 only while ale is low and no
        // memory cycle is open; data on d0-d3 later cannot disturb
        // the page decode of the cycle in progress
        if (~mcsync_n && memreq_n) begin
            next_st.hi_addr = data_in[HI_ADDR_LSB +: HI_ADDR_W];
        end

        // track the kind of cycle for the bus side
        unique case (st.cyc)
            PDCB_IDLE: begin
                if (refr_cycle) begin
                    next_st.cyc = PDCB_REFR;
                end else if (mem_sel) begin
                    next_st.cyc = PDCB_MEM;
                end else if (io_sel) begin
                    next_st.cyc = PDCB_IO;
                end
            end
            PDCB_MEM: begin
                if (memreq_n) begin
                    next_st.cyc = PDCB_IDLE;
                end
            end
            PDCB_REFR: begin
                if (memreq_n) begin
                    next_st.cyc = PDCB_IDLE;
                end
            end
            PDCB_IO: begin
                if (iorq_n) begin
                    next_st.cyc = PDCB_IDLE;
                end
            end
        endcase

        // refresh runs whatever the enable says; a8-a15 unused
        if (refr_cycle && mreq_fall) begin
            next_st.refr_req = 1'b1;
            next_st.refr_row = addr[REFR_ROW_W-1:0];
        end

        // memory write: take the byte as the write strobe falls
        if (mem_sel && wr_fall) begin
            next_st.ram_we = 1'b1;
            next_st.ram_addr = full_addr[RAM_ADDR_W-1:0];
            next_st.ram_wdata = {gen_parity, data_in};
        end

        // memory read: fetch now, word lands one cycle later
        if (mem_sel && rd_fall) begin
            next_st.ram_rd = 1'b1;
            next_st.ram_addr = full_addr[RAM_ADDR_W-1:0];
        end
        if (st.ram_rd) begin
            next_st.rd_pend = 1'b1;
        end
        if (st.rd_pend) begin
            next_st.dout = ram_rdata[DATA_W-1:0];
        end

        // control port read shows flag and enable
        if (io_sel && rd_fall) begin
            next_st.dout = {st.par_err, st.card_en, CTRL_UNUSED_READ};
        end

        // control port write sets enable and clears the flag
        if (io_sel && wr_fall) begin
            next_st.card_en = data_in[CTRL_ENABLE_BIT];
            next_st.par_err = 1'b0;
        end

        // a mismatch set in the clearing cycle still wins
        if (st.rd_pend && chk_error) begin
            next_st.par_err = 1'b1;
        end
    end

    // =========================================================
    // state register, reset disables the card
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // outputs
    // transceiver opens only while the read strobe is low on an own
    // cycle and closes in the same cycle the strobe rises; on a
    // memory read the byte is valid three cycles after the strobe fell
    assign data_oe = ~rd_n & (mem_sel | io_sel);
    assign data_out = st.dout;
    assign ram_addr = st.ram_addr;
    assign ram_wdata = st.ram_wdata;
    assign ram_we = st.ram_we;
    assign ram_rd = st.ram_rd;
    assign refresh_req = st.refr_req;
    assign refresh_row = st.refr_row;
    assign card_enable = st.card_en;
    assign parity_error_flag = st.par_err;

endmodule

`default_nettype wire

// ===== verilog/pdcb_pkg.sv
// package of constants and types for the paged dram card bus slave
// assumes a single 25 MHz clock and strobes already synchronous to it
package pdcb_pkg;

    // =========================================================
    // clock
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;

    // =========================================================
    // backplane widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int HI_ADDR_W = 4;
    localparam int FULL_ADDR_W = 20;
    localparam int PAGES = 4;
    localparam int RAM_ADDR_W = 18;
    localparam int RAM_WORD_W = 9;
    localparam int REFR_ROW_W = 8;
    localparam int PORT_ADDR_W = 8;

    // =========================================================
    // field positions
    localparam int HI_ADDR_LSB = 0;
    localparam int PAGE_SEL_MSB = 3;
    localparam int PAGE_SEL_LSB = 2;
    localparam int RAM_PARITY_BIT = 8;

    // =========================================================
    // control port layout
    localparam int CTRL_ENABLE_BIT = 6;
    localparam int CTRL_PARERR_BIT = 7;
    localparam logic [5:0] CTRL_UNUSED_READ = 6'h00;

    // =========================================================
    // values after reset
    localparam logic CARD_EN_RESET = 1'b0;
    localparam logic PARERR_RESET = 1'b0;
    localparam logic [3:0] HI_ADDR_RESET = 4'h0;
    localparam logic [7:0] DOUT_RESET = 8'h00;
    localparam logic [17:0] RAM_ADDR_RESET = 18'h00000;
    localparam logic [8:0] RAM_WDATA_RESET = 9'h000;
    localparam logic [7:0] REFR_ROW_RESET = 8'h00;

    // =========================================================
    // cycles
    localparam int RAM_READ_LATENCY = 1;

    // kind of backplane cycle in progress
    typedef enum logic [1:0] {
        PDCB_IDLE = 2'b00,
        PDCB_MEM  = 2'b01,
        PDCB_REFR = 2'b10,
        PDCB_IO   = 2'b11
    } pdcb_cyc_e;

endpackage

// ===== verilog/pdcb_parity_unit.sv
// odd parity generator for stored bytes and checker for fetched words
// assumes stored words carry the parity bit above the data byte
`timescale 1ns/10ps
`default_nettype none

module pdcb_parity_unit (
    // byte headed for the ram
    input wire logic [pdcb_pkg::DATA_W-1:0] wr_byte,
    output logic wr_parity,
    // word coming back from the ram
    input wire logic [pdcb_pkg::RAM_WORD_W-1:0] rd_word,
    output logic rd_error
);
    import pdcb_pkg::*;

    // =========================================================
    // generation and check
    // parity bit makes the count of ones odd across nine bits
    assign wr_parity = ~(^wr_byte);
    // an even count over the stored nine bits is a mismatch
    assign rd_error = ~(^rd_word);

endmodule

`default_nettype wire

// ===== bench/pdcb_card_checker.sv
// assertions on the ports of the paged dram card front end
// assumes strobes synchronous to clk, ram answering one cycle after ram_rd
`timescale 1ns/10ps
`default_nettype none
module pdcb_card_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // backplane
    input wire logic [pdcb_pkg::ADDR_W-1:0] addr,
    input wire logic [pdcb_pkg::DATA_W-1:0] data_in,
    input wire logic [pdcb_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic mcsync_n,
    input wire logic memreq_n,
    input wire logic iorq_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic refresh_n,
    input wire logic m1_n,
    input wire logic emul_mode,
    input wire logic [pdcb_pkg::PORT_ADDR_W-1:0] port_number_jumpers,
    input wire logic [pdcb_pkg::PAGES-1:0] page_select_jumpers,
    // ram side and status
    input wire logic [pdcb_pkg::RAM_ADDR_W-1:0] ram_addr,
    input wire logic [pdcb_pkg::RAM_WORD_W-1:0] ram_wdata,
    input wire logic ram_we,
    input wire logic ram_rd,
    input wire logic [pdcb_pkg::RAM_WORD_W-1:0] ram_rdata,
    input wire logic refresh_req,
    input wire logic [pdcb_pkg::REFR_ROW_W-1:0] refresh_row,
    input wire logic card_enable,
    input wire logic parity_error_flag
);
    import pdcb_pkg::*;
    logic [3:0] hi_q;
    wire [17:0] full_addr = {hi_q[1:0], addr};
    wire [7:0] lo_addr = addr[7:0];
    wire [7:0] rd_byte = ram_rdata[7:0];
    wire en_bit = data_in[6];
    wire page_hit = page_select_jumpers[hi_q[3:2]];
    wire mem_ok = !memreq_n && refresh_n && card_enable && page_hit;
    wire port_ok = emul_mode && !iorq_n && m1_n &&
        lo_addr == port_number_jumpers;
    // =========================================================
    // own copy of the high address, frozen inside a memory cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_q <= 4'h0;
        end else if (!mcsync_n && memreq_n) begin
            hi_q <= data_in[3:0];
        end
    end
    // =========================================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence rd_go;
        $fell(rd_n) && mem_ok;
    endsequence
    a_read_data: assert property (
        rd_go |=> ram_rd ##2 data_out == $past(rd_byte))
        else $error("read byte not returned");
    a_parity_flag: assert property (
        rd_go ##1 ram_rd ##1 !(^ram_rdata) |=> parity_error_flag)
        else $error("parity error not flagged");
    a_write_store: assert property (
        $fell(wr_n) && mem_ok |=> ram_we && ram_wdata[7:0] ==
        $past(data_in) && ram_addr == $past(full_addr))
        else $error("write not stored");
    a_ram_qualified: assert property (
        ram_we || ram_rd |-> $past(mem_ok))
        else $error("ram access without decode");
    a_parity_odd: assert property (ram_we |-> ^ram_wdata)
        else $error("stored parity not odd");
    a_oe_gate: assert property (
        data_oe |-> !rd_n && (mem_ok || port_ok))
        else $error("data driven out of turn");
    a_refresh_row: assert property (
        $fell(memreq_n) && !refresh_n |=> refresh_req &&
        refresh_row == $past(lo_addr))
        else $error("refresh row wrong");
    a_refresh_only: assert property (
        !refresh_n |-> !ram_we && !ram_rd)
        else $error("refresh made a ram access");
    a_port_write: assert property (
        $fell(wr_n) && port_ok |=> card_enable == $past(en_bit) &&
        !parity_error_flag)
        else $error("port write not taken");
    a_ack_ignored: assert property (
        $fell(wr_n) && !iorq_n && !(m1_n && emul_mode) |=>
        $stable(card_enable))
        else $error("acknowledge treated as port write");
endmodule
`default_nettype wire

// ===== bench/pdcb_ram_model.sv
// dram stand-in behind the card, answering a read one cycle later
// assumes ram_we and ram_rd are single-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none
module pdcb_ram_model (
    // clock
    input wire logic clk,
    // ram port of the card
    input wire logic [pdcb_pkg::RAM_ADDR_W-1:0] ram_addr,
    input wire logic [pdcb_pkg::RAM_WORD_W-1:0] ram_wdata,
    input wire logic ram_we,
    input wire logic ram_rd,
    output logic [pdcb_pkg::RAM_WORD_W-1:0] ram_rdata,
    // bench command: hand back the parity bit inverted
    input wire logic flip
);
    import pdcb_pkg::*;
    logic [RAM_WORD_W-1:0] mem [0:255];
    initial ram_rdata = 9'h0aa;
    // =========================================================
    // store and fetch; idle lines toggle so stale data never looks valid
    always @(posedge clk) begin
        if (ram_we) begin
            mem[{ram_addr[17:16], ram_addr[5:0]}] <= ram_wdata;
        end
        if (ram_rd) begin
            ram_rdata <= mem[{ram_addr[17:16], ram_addr[5:0]}] ^ {flip, 8'h00};
        end else begin
            ram_rdata <= ~ram_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== bench/pdcb_card_bench.sv
// self-checking bench for the paged dram card front end
// assumes checker and ram model compiled before this file
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module pdcb_card_bench;
    import pdcb_pkg::*;
    logic clk, rst_n, mcsync_n, memreq_n, iorq_n, rd_n, wr_n, refresh_n, m1_n;
    logic emul_mode, data_oe, ram_we, ram_rd, refresh_req, card_enable, flip;
    logic parity_error_flag, oe;
    logic [1:0] pg;
    logic [3:0] page_select_jumpers;
    logic [7:0] data_in, data_out, port_number_jumpers, refresh_row, q;
    logic [8:0] ram_wdata, ram_rdata;
    logic [15:0] addr;
    logic [17:0] ram_addr;
    int miscompares = 0;
    int num_checks = 0;
    pdcb_card i_pdcb_card (.*);
    pdcb_ram_model i_pdcb_ram_model (.*);
    // =========================================================
    // one bus cycle: 0/1 mem wr/rd, 2/3 port wr/rd, 4 refresh
    task automatic cyc(input int k, input logic [3:0] hi,
            input logic [15:0] a, input logic [7:0] d);
        mcsync_n <= k[1]; // ale ahead of memory and refresh
        data_in <= {4'h0, hi}; // hi bits on d0-d3
        addr <= a;
        @(posedge clk);
        mcsync_n <= 1'b1;
        memreq_n <= k[1];
        iorq_n <= !k[1];
        refresh_n <= !k[2];
        data_in <= d;
        @(posedge clk);
        mcsync_n <= k[1]; // ale again mid-cycle, must be ignored
        wr_n <= k[0] || k[2];
        rd_n <= !k[0] && !k[2]; // refresh also pulls rd low
        repeat (4) @(posedge clk);
        #1 q = data_out;
        oe = data_oe;
        @(posedge clk);
        {mcsync_n, memreq_n, iorq_n, rd_n, wr_n, refresh_n} <= 6'h3f;
        data_in <= ~d;
        @(posedge clk);
    endtask
    task close_out;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // =========================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out();
    end
    // =========================================================
    // main sequence
    initial begin
        // emulation mode on from the start, reset, flip, address and data low, strobes high
        {rst_n, flip, emul_mode, addr, data_in} = 27'h1000000;
        {mcsync_n, memreq_n, iorq_n, rd_n, wr_n, refresh_n, m1_n} = 7'h7f;
        port_number_jumpers = 8'h70;
        page_select_jumpers = 4'h1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cyc(3, 4'h0, 16'ha570, 8'h00);
        `CHK({oe, q}, 9'h100)
        cyc(2, 4'h0, 16'h5a70, 8'h40);
        cyc(3, 4'h0, 16'h0070, 8'h00);
        `CHK(q, 8'h40)
        for (int i = 0; i < 4; i++) begin
            pg = i[1:0];
            page_select_jumpers <= 4'h1 << pg;
            cyc(0, {pg, 2'h1}, {14'h048c, pg}, {6'h0f, pg});
            cyc(1, {pg, 2'h1}, {14'h048c, pg}, 8'h00);
            `CHK({oe, q}, {1'b1, 6'h0f, pg})
            cyc(1, {pg + 2'h1, 2'h1}, {14'h048c, pg}, 8'h00);
            `CHK(oe, 1'b0)
        end
        // refresh in the enabled page with rd low: no read may start
        cyc(4, 4'hd, 16'hff5a, 8'h00);
        `CHK(refresh_row, 8'h5a)
        `CHK(oe, 1'b0)
        m1_n <= 1'b0;
        cyc(2, 4'h0, 16'h0070, 8'h00);
        m1_n <= 1'b1;
        emul_mode <= 1'b0;
        cyc(2, 4'h0, 16'h0070, 8'h00);
        emul_mode <= 1'b1;
        cyc(3, 4'h0, 16'h0070, 8'h00);
        `CHK(q, 8'h40)
        flip <= 1'b1;
        cyc(1, 4'hd, 16'h1233, 8'h00);
        flip <= 1'b0;
        `CHK(q, 8'h3f)
        cyc(3, 4'h0, 16'h0070, 8'h00);
        `CHK(q, 8'hc0)
        cyc(2, 4'h0, 16'h0070, 8'h00);
        cyc(1, 4'hd, 16'h1233, 8'h00);
        `CHK(oe, 1'b0)
        cyc(3, 4'h0, 16'h0070, 8'h00);
        `CHK(q, 8'h00)
        cyc(4, 4'h0, 16'h00c3, 8'h00);
        `CHK(refresh_row, 8'hc3)
        cyc(2, 4'h0, 16'h0070, 8'h40);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cyc(3, 4'h0, 16'h0070, 8'h00);
        `CHK({oe, q}, 9'h100)
        close_out();
    end
endmodule
bind pdcb_card pdcb_card_checker i_pdcb_card_checker (.*);
`default_nettype wire
